/* hw/sdl_pkg.sv */
// Constants and types for the servo drive I/O and limit logic
package sdl_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int MS_PER_TICK = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * MS_PER_TICK;
    localparam int TICK_W = 16;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam int RMS_TICKS_PER_SEC = 1000;
    localparam int NUM_IN = 9;
    localparam int NUM_OUT = 8;
    localparam int IN_STOP_MARKER = 1;
    localparam int IN_TORQUE_LIMIT_EN = 2;
    localparam int IN_TORQUE_SEL = 3;
    localparam int IN_POSITION_SEL = 4;
    localparam int OUT_COINCIDENCE = 0;
    localparam logic [8:0] INPUT_INVERT_RST = 9'h000;
    localparam logic [7:0] OUTPUT_INVERT_RST = 8'h00;
    localparam logic [9:0] PCT_FULL = 10'h3E8;
    localparam logic [11:0] JOG_SPEED_RST = 12'h032;
    localparam logic [11:0] JOG_SPEED_MIN = 12'h001;
    localparam logic [11:0] JOG_SPEED_MAX = 12'hFA0;
    localparam logic [5:0] RMS_TC_RST = 6'h1E;
    localparam logic [5:0] RMS_TC_MIN = 6'h01;
    localparam logic [5:0] RMS_TC_MAX = 6'h3C;
    localparam logic [7:0] TL_METHOD_RST = 8'h11;
    localparam logic [14:0] RATIO_RST = 15'h0001;
    localparam logic [2:0] POINT_POS_RST = 3'h0;
    localparam logic [7:0] COIN_WIDTH_RST = 8'h14;
    localparam logic [7:0] COIN_WIDTH_MAX = 8'hC8;
    localparam logic [1:0] TLM_ANALOG = 2'h0;
    localparam logic [1:0] TLM_PARAM_EN = 2'h1;
    localparam logic [1:0] TLM_PARAM_ALWAYS = 2'h2;
    typedef enum logic [1:0] {MODE_SPEED, MODE_TORQUE, MODE_POSITION} sdl_mode_t;
endpackage

/* hw/sdl_tick_if.sv */
// Interface carrying the millisecond tick between drive modules
`timescale 1ns/1ps
interface sdl_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

/* hw/sdl_ms_tick.sv */
// Millisecond tick generator from the control clock
`timescale 1ns/1ps
module sdl_ms_tick
    import sdl_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Tick out
    sdl_tick_if.src tk
);
    logic [TICK_W-1:0] cnt_q;
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            cnt_q <= '0;
        else if (cnt_q == TICK_LAST)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end
    assign tk.tick = (cnt_q == TICK_LAST);
endmodule

/* hw/sdl_servo_logic.sv */
// Servo drive I/O, mode, brake, torque limit and display logic
`timescale 1ns/1ps
module sdl_servo_logic
    import sdl_pkg::*;
(
    // Clock and reset (reset is power cycling)
    input wire logic MCLK,
    input wire logic NRST,
    // Discrete pins
    input wire logic [NUM_IN-1:0] DISCRETE_IN,
    output logic [NUM_OUT-1:0] DISCRETE_OUT,
    // Raw coincidence and marker status from the position loop
    input wire logic COINCIDENCE_RAW,
    input wire logic AT_MARKER,
    // Command pulse count step and polarity
    input wire logic CMD_STEP,
    input wire logic CMD_UP,
    input wire logic CMD_POLARITY,
    output logic MOTOR_STEP,
    output logic MOTOR_CW,
    // Brake
    input wire logic [1:0] BRAKE_MODE,
    input wire logic [9:0] BRAKE_THRESHOLD,
    input wire logic [9:0] SPEED_PCT,
    output logic BRAKE_ENGAGE,
    // Keypad jog
    input wire logic JOG_REQ,
    input wire logic [11:0] JOG_SPEED,
    output logic JOG_ACTIVE,
    output logic [11:0] JOG_SPEED_CMD,
    // Regen settings
    input wire logic [9:0] REGEN_OHMS,
    input wire logic [15:0] REGEN_KW,
    output logic [9:0] REGEN_OHMS_ACT,
    output logic [15:0] REGEN_KW_ACT,
    output logic REGEN_INTERNAL,
    // Rms torque
    input wire logic [5:0] RMS_TORQUE_TIME_CONST,
    input wire logic [9:0] TORQUE_PCT,
    output logic [9:0] RMS_TORQUE_READOUT,
    // Torque and speed limits
    input wire logic [7:0] TORQUE_LIMIT_METHOD,
    input wire logic [9:0] SECOND_ANALOG_REFERENCE,
    input wire logic [9:0] GENERAL_TORQUE_LIMIT,
    input wire logic [9:0] CCW_MOTORING_TORQUE_LIMIT,
    input wire logic [9:0] CCW_BRAKING_TORQUE_LIMIT,
    input wire logic [9:0] CW_MOTORING_TORQUE_LIMIT,
    input wire logic [9:0] CW_BRAKING_TORQUE_LIMIT,
    input wire logic [9:0] SPEED_LIMIT_ANALOG,
    input wire logic [9:0] SPEED_LIMIT_PARAM,
    input wire logic SPEED_LIMIT_USE_ANALOG,
    input wire logic ROT_CW,
    input wire logic TORQUE_CW,
    output logic TORQUE_LIMIT_ACTIVE,
    output logic [9:0] TORQUE_LIMIT_PCT,
    output logic SPEED_LIMIT_ACTIVE,
    output logic [9:0] SPEED_LIMIT_PCT,
    // Speed display
    input wire logic [15:0] MOTOR_SPEED,
    input wire logic [14:0] SPEED_DISPLAY_NUMERATOR,
    input wire logic [14:0] SPEED_DISPLAY_DENOMINATOR,
    input wire logic [2:0] SPEED_DISPLAY_POINT_POS,
    output logic [15:0] SPEED_DISPLAY,
    output logic [2:0] SPEED_POINT_POS,
    // Masks and coincidence width
    input wire logic [8:0] INPUT_INVERT_MASK,
    input wire logic [7:0] OUTPUT_INVERT_MASK,
    input wire logic [7:0] COINCIDENCE_MIN_WIDTH,
    input wire logic [NUM_OUT-1:0] OUT_FUNC,
    // Mode status
    output sdl_mode_t CONTROL_MODE,
    output logic MARKER_STOP,
    output logic POSITION_LOCK
);
    sdl_tick_if tk_if();
    sdl_ms_tick u_tick (.MCLK(MCLK), .NRST(NRST), .tk(tk_if));

    logic [NUM_IN-1:0] in_q;
    logic [NUM_OUT-1:0] out_func;
    logic [NUM_OUT-1:0] out_q;
    logic coin_q;
    logic [7:0] coin_cnt_q;
    logic coin_raw_q;
    logic [1:0] brake_mode_q;
    logic [9:0] brake_thr_q;
    logic [11:0] jog_q;
    logic [5:0] rms_tc_q;
    logic [7:0] tlm_q;
    logic [7:0] coin_w_q;
    logic [14:0] num_q;
    logic [14:0] den_q;
    logic [2:0] point_q;
    logic [8:0] imask_q;
    logic [7:0] omask_q;
    logic regen_loaded_q;

    // Settings are captured once per cycle; regen is latched only after reset
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            brake_mode_q <= 2'h0;
            brake_thr_q <= PCT_FULL;
            jog_q <= JOG_SPEED_RST;
            rms_tc_q <= RMS_TC_RST;
            tlm_q <= TL_METHOD_RST;
            coin_w_q <= COIN_WIDTH_RST;
            num_q <= RATIO_RST;
            den_q <= RATIO_RST;
            point_q <= POINT_POS_RST;
            imask_q <= INPUT_INVERT_RST;
            omask_q <= OUTPUT_INVERT_RST;
        end
        else
        begin
            brake_mode_q <= BRAKE_MODE;
            brake_thr_q <= (BRAKE_THRESHOLD > PCT_FULL) ? PCT_FULL : BRAKE_THRESHOLD;
            jog_q <= (JOG_SPEED < JOG_SPEED_MIN) ? JOG_SPEED_MIN :
                     (JOG_SPEED > JOG_SPEED_MAX) ? JOG_SPEED_MAX : JOG_SPEED;
            rms_tc_q <= (RMS_TORQUE_TIME_CONST < RMS_TC_MIN) ? RMS_TC_MIN :
                        (RMS_TORQUE_TIME_CONST > RMS_TC_MAX) ? RMS_TC_MAX : RMS_TORQUE_TIME_CONST;
            tlm_q <= TORQUE_LIMIT_METHOD;
            coin_w_q <= (COINCIDENCE_MIN_WIDTH > COIN_WIDTH_MAX) ? COIN_WIDTH_MAX : COINCIDENCE_MIN_WIDTH;
            num_q <= (SPEED_DISPLAY_NUMERATOR == 15'h0000) ? RATIO_RST : SPEED_DISPLAY_NUMERATOR;
            den_q <= (SPEED_DISPLAY_DENOMINATOR == 15'h0000) ? RATIO_RST : SPEED_DISPLAY_DENOMINATOR;
            point_q <= SPEED_DISPLAY_POINT_POS;
            imask_q <= INPUT_INVERT_MASK;
            omask_q <= OUTPUT_INVERT_MASK;
        end
    end

    // Regen values are taken on the first cycle after power-up and then frozen
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            regen_loaded_q <= 1'b0;
            REGEN_OHMS_ACT <= 10'h000;
            REGEN_KW_ACT <= 16'h0000;
        end
        else if (!regen_loaded_q)
        begin
            regen_loaded_q <= 1'b1;
            REGEN_OHMS_ACT <= REGEN_OHMS;
            REGEN_KW_ACT <= REGEN_KW;
        end
    end
    assign REGEN_INTERNAL = (REGEN_OHMS_ACT == 10'h000);

    // Input and output inversion applied at the pins
    generate
        for (genvar i = 0; i < NUM_IN; i++)
        begin : g_in
            always_ff @(posedge MCLK)
            begin
                if (!NRST)
                    in_q[i] <= 1'b0;
                else
                    in_q[i] <= DISCRETE_IN[i] ^ imask_q[i];
            end
        end
        for (genvar j = 0; j < NUM_OUT; j++)
        begin : g_out
            always_ff @(posedge MCLK)
            begin
                if (!NRST)
                    out_q[j] <= 1'b0;
                else
                    out_q[j] <= out_func[j] ^ omask_q[j];
            end
        end
    endgenerate
    assign DISCRETE_OUT = out_q;

    always_comb
    begin
        out_func = OUT_FUNC;
        out_func[OUT_COINCIDENCE] = coin_q;
    end

    // Coincidence stretch: restart on each rising edge, hold for the minimum width
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            coin_raw_q <= 1'b0;
            coin_q <= 1'b0;
            coin_cnt_q <= 8'h00;
        end
        else
        begin
            coin_raw_q <= COINCIDENCE_RAW;
            if (COINCIDENCE_RAW && !coin_raw_q)
            begin
                coin_q <= 1'b1;
                // One extra count covers the partial first tick, so the pulse is never short
                coin_cnt_q <= (coin_w_q == 8'h00) ? 8'h00 : coin_w_q + 8'h01;
            end
            else if (coin_cnt_q != 8'h00)
            begin
                coin_q <= 1'b1;
                if (tk_if.tick)
                    coin_cnt_q <= coin_cnt_q - 8'h01;
            end
            else
                coin_q <= COINCIDENCE_RAW;
        end
    end

    // Control mode from the corrected select inputs
    sdl_mode_t mode_d;
    always_comb
    begin
        if (in_q[IN_TORQUE_SEL])
            mode_d = MODE_TORQUE;
        else if (in_q[IN_POSITION_SEL])
            mode_d = MODE_POSITION;
        else
            mode_d = MODE_SPEED;
    end
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            CONTROL_MODE <= MODE_SPEED;
        else
            CONTROL_MODE <= mode_d;
    end

    // Stop at marker: position lock holds until the input drops
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            MARKER_STOP <= 1'b0;
            POSITION_LOCK <= 1'b0;
        end
        else
        begin
            MARKER_STOP <= in_q[IN_STOP_MARKER];
            if (!in_q[IN_STOP_MARKER])
                POSITION_LOCK <= 1'b0;
            else if (AT_MARKER)
                POSITION_LOCK <= 1'b1;
        end
    end

    // Command direction
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            MOTOR_STEP <= 1'b0;
            MOTOR_CW <= 1'b0;
        end
        else
        begin
            MOTOR_STEP <= CMD_STEP && !POSITION_LOCK;
            if (CMD_STEP)
                MOTOR_CW <= CMD_POLARITY ? CMD_UP : !CMD_UP;
        end
    end

    // Brake
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            BRAKE_ENGAGE <= 1'b0;
        else if (brake_mode_q == 2'h0)
            BRAKE_ENGAGE <= 1'b0;
        else if (brake_mode_q == 2'h1 || brake_mode_q == 2'h2)
            BRAKE_ENGAGE <= (SPEED_PCT < brake_thr_q);
        else
            BRAKE_ENGAGE <= 1'b0;
    end

    // Keypad jog
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            JOG_ACTIVE <= 1'b0;
            JOG_SPEED_CMD <= 12'h000;
        end
        else
        begin
            JOG_ACTIVE <= JOG_REQ;
            JOG_SPEED_CMD <= JOG_REQ ? jog_q : 12'h000;
        end
    end

    // Rms torque: first-order filter of squared torque, stepped each millisecond
    logic [31:0] rms_acc_q;
    logic [19:0] tsq;
    logic [15:0] tc_ms;
    logic signed [32:0] rms_diff;
    logic [31:0] rms_step;
    logic [9:0] rms_root;
    assign tsq = 20'(TORQUE_PCT) * 20'(TORQUE_PCT);
    assign tc_ms = 16'(rms_tc_q) * 16'(RMS_TICKS_PER_SEC);
    // Signed difference so the average can also fall when torque drops
    assign rms_diff = $signed({1'b0, tsq, 12'h000}) - $signed({1'b0, rms_acc_q});
    assign rms_step = 32'(rms_diff / $signed({17'h00000, tc_ms}));
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            rms_acc_q <= 32'h00000000;
        else if (tk_if.tick)
            rms_acc_q <= rms_acc_q + rms_step;
    end
    // Bitwise square root; slow combinational path, traded for no extra state
    always_comb
    begin
        logic [19:0] mean;
        logic [9:0] r;
        mean = rms_acc_q[31:12];
        r = 10'h000;
        for (int b = 9; b >= 0; b--)
        begin
            r[b] = 1'b1;
            if (20'(r) * 20'(r) > mean)
                r[b] = 1'b0;
        end
        rms_root = r;
    end
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            RMS_TORQUE_READOUT <= 10'h000;
        else
            RMS_TORQUE_READOUT <= rms_root;
    end

    // Torque limit selection (speed and position) and speed limit (torque mode)
    logic [9:0] quad_lim;
    logic [9:0] par_lim;
    logic tl_en_d;
    logic [9:0] tl_pct_d;
    logic motoring;
    assign motoring = (ROT_CW == TORQUE_CW);
    always_comb
    begin
        if (!ROT_CW)
            quad_lim = motoring ? CCW_MOTORING_TORQUE_LIMIT : CCW_BRAKING_TORQUE_LIMIT;
        else
            quad_lim = motoring ? CW_MOTORING_TORQUE_LIMIT : CW_BRAKING_TORQUE_LIMIT;
        par_lim = (GENERAL_TORQUE_LIMIT == 10'h000) ? quad_lim : GENERAL_TORQUE_LIMIT;
        case (tlm_q[5:4])
            TLM_ANALOG:
            begin
                tl_en_d = in_q[IN_TORQUE_LIMIT_EN];
                tl_pct_d = SECOND_ANALOG_REFERENCE;
            end
            TLM_PARAM_EN:
            begin
                tl_en_d = in_q[IN_TORQUE_LIMIT_EN];
                tl_pct_d = par_lim;
            end
            TLM_PARAM_ALWAYS:
            begin
                tl_en_d = 1'b1;
                tl_pct_d = par_lim;
            end
            default:
            begin
                tl_en_d = 1'b0;
                tl_pct_d = PCT_FULL;
            end
        endcase
        if (tl_pct_d > PCT_FULL)
            tl_pct_d = PCT_FULL;
        if (mode_d == MODE_TORQUE)
            tl_en_d = 1'b0;
    end
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            TORQUE_LIMIT_ACTIVE <= 1'b0;
            TORQUE_LIMIT_PCT <= PCT_FULL;
            SPEED_LIMIT_ACTIVE <= 1'b0;
            SPEED_LIMIT_PCT <= PCT_FULL;
        end
        else
        begin
            TORQUE_LIMIT_ACTIVE <= tl_en_d;
            TORQUE_LIMIT_PCT <= tl_en_d ? tl_pct_d : PCT_FULL;
            SPEED_LIMIT_ACTIVE <= (mode_d == MODE_TORQUE);
            SPEED_LIMIT_PCT <= (mode_d != MODE_TORQUE) ? PCT_FULL :
                               SPEED_LIMIT_USE_ANALOG ? SPEED_LIMIT_ANALOG : SPEED_LIMIT_PARAM;
        end
    end

    // Speed display scaling
    logic [30:0] prod;
    assign prod = 31'(MOTOR_SPEED) * 31'(num_q);
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
        begin
            SPEED_DISPLAY <= 16'h0000;
            SPEED_POINT_POS <= POINT_POS_RST;
        end
        else
        begin
            SPEED_DISPLAY <= 16'(prod / 31'(den_q));
            SPEED_POINT_POS <= point_q;
        end
    end
endmodule

/* sim/sdl_properties.sv */
// Port-level assertions for the servo drive logic
`timescale 1ns/1ps
module sdl_properties
    import sdl_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Inputs watched
    input wire logic [NUM_IN-1:0] DISCRETE_IN,
    input wire logic [8:0] INPUT_INVERT_MASK,
    input wire logic CMD_STEP,
    input wire logic CMD_UP,
    input wire logic CMD_POLARITY,
    input wire logic [1:0] BRAKE_MODE,
    input wire logic [9:0] BRAKE_THRESHOLD,
    input wire logic [9:0] SPEED_PCT,
    input wire logic [7:0] TORQUE_LIMIT_METHOD,
    input wire logic [NUM_OUT-1:0] OUT_FUNC,
    input wire logic [7:0] OUTPUT_INVERT_MASK,
    // Outputs watched
    input wire logic [NUM_OUT-1:0] DISCRETE_OUT,
    input wire logic MOTOR_STEP,
    input wire logic MOTOR_CW,
    input wire logic BRAKE_ENGAGE,
    input wire logic [9:0] REGEN_OHMS_ACT,
    input wire logic [15:0] REGEN_KW_ACT,
    input wire logic REGEN_INTERNAL,
    input wire logic TORQUE_LIMIT_ACTIVE,
    input wire logic SPEED_LIMIT_ACTIVE,
    input wire sdl_mode_t CONTROL_MODE,
    input wire logic POSITION_LOCK
);
    logic [8:0] pin;
    logic [1:0] since_q;
    assign pin = DISCRETE_IN ^ INPUT_INVERT_MASK;
    // Regen copies are captured on the first edge after reset, so stability is judged later
    always_ff @(posedge MCLK)
    begin
        if (!NRST)
            since_q <= 2'h0;
        else if (since_q != 2'h3)
            since_q <= since_q + 2'h1;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    sequence s_two(b);
        (b && $stable(INPUT_INVERT_MASK)) ##1 (b && $stable(INPUT_INVERT_MASK));
    endsequence
    sequence s_calm;
        ($stable(OUT_FUNC) && $stable(OUTPUT_INVERT_MASK)) [*3];
    endsequence
    mode_torque_a: assert property (s_two(pin[IN_TORQUE_SEL]) |=> CONTROL_MODE == MODE_TORQUE)
        else $error("torque select not followed");
    mode_position_a: assert property (s_two(pin[4:3] == 2'h2) |=> CONTROL_MODE == MODE_POSITION)
        else $error("position select not followed");
    mode_speed_a: assert property (s_two(pin[4:3] == 2'h0) |=> CONTROL_MODE == MODE_SPEED)
        else $error("speed mode not followed");
    torque_mode_a: assert property (CONTROL_MODE == MODE_TORQUE |-> SPEED_LIMIT_ACTIVE && !TORQUE_LIMIT_ACTIVE)
        else $error("torque mode limits wrong");
    step_dir_a: assert property (CMD_STEP && !POSITION_LOCK
        |=> MOTOR_STEP && MOTOR_CW == ($past(CMD_UP) == $past(CMD_POLARITY)))
        else $error("step direction wrong");
    lock_step_a: assert property (POSITION_LOCK |=> !MOTOR_STEP)
        else $error("step passed while locked");
    brake_low_a: assert property ((BRAKE_MODE inside {2'h1, 2'h2} && SPEED_PCT < BRAKE_THRESHOLD) [*3]
        |=> BRAKE_ENGAGE)
        else $error("brake not engaged below threshold");
    out_invert_a: assert property (s_calm |-> DISCRETE_OUT[7:1] == (OUT_FUNC[7:1] ^ OUTPUT_INVERT_MASK[7:1]))
        else $error("output inversion wrong");
    limit_always_a: assert property ((TORQUE_LIMIT_METHOD[7:4] == 4'h2 && !pin[IN_TORQUE_SEL]) [*3]
        |=> TORQUE_LIMIT_ACTIVE)
        else $error("method two limit missing");
    limit_gated_a: assert property ((TORQUE_LIMIT_METHOD[7:4] < 4'h2 && !pin[IN_TORQUE_LIMIT_EN]) [*3]
        |=> !TORQUE_LIMIT_ACTIVE)
        else $error("limit active without enable");
    regen_hold_a: assert property (since_q == 2'h3 |-> $stable(REGEN_OHMS_ACT) && $stable(REGEN_KW_ACT))
        else $error("regen value changed after startup");
    regen_int_a: assert property (REGEN_INTERNAL == (REGEN_OHMS_ACT == 10'h000))
        else $error("internal regen select wrong");
endmodule
bind sdl_servo_logic sdl_properties u_props (.MCLK, .NRST, .DISCRETE_IN, .INPUT_INVERT_MASK, .CMD_STEP, .CMD_UP,
    .CMD_POLARITY, .BRAKE_MODE, .BRAKE_THRESHOLD, .SPEED_PCT, .TORQUE_LIMIT_METHOD, .OUT_FUNC,
    .OUTPUT_INVERT_MASK, .DISCRETE_OUT, .MOTOR_STEP, .MOTOR_CW, .BRAKE_ENGAGE, .REGEN_OHMS_ACT, .REGEN_KW_ACT,
    .REGEN_INTERNAL, .TORQUE_LIMIT_ACTIVE, .SPEED_LIMIT_ACTIVE, .CONTROL_MODE, .POSITION_LOCK);

/* sim/sdl_ctrl_model.sv */
// Machine controller model driving discrete inputs and command pulses
`timescale 1ns/1ps
module sdl_ctrl_model
    import sdl_pkg::*;
(
    // Clock
    input wire logic MCLK,
    // Controller outputs
    output logic [NUM_IN-1:0] DISCRETE_IN,
    output logic CMD_STEP,
    output logic CMD_UP
);
    initial
    begin
        DISCRETE_IN = '0;
        CMD_STEP = 1'b0;
        CMD_UP = 1'b0;
    end
    task automatic sel(input logic t, input logic p);
        DISCRETE_IN[IN_TORQUE_SEL] = t;
        DISCRETE_IN[IN_POSITION_SEL] = p;
    endtask
    task automatic pin(input int k, input logic v);
        DISCRETE_IN[k] = v;
    endtask
    // One count step, held across exactly one sampling edge
    task automatic step(input logic up);
        CMD_UP = up;
        CMD_STEP = 1'b1;
        @(posedge MCLK);
        #2;
        CMD_STEP = 1'b0;
    endtask
endmodule

/* sim/sdl_servo_logic_tb.sv */
// Self-checking bench of the servo drive logic
`timescale 1ns/1ps
module sdl_servo_logic_tb;
    import sdl_pkg::*;
    logic MCLK = 1'b0, NRST = 1'b0, COINCIDENCE_RAW = 1'b0, AT_MARKER = 1'b0, CMD_POLARITY = 1'b0;
    logic JOG_REQ = 1'b0, SPEED_LIMIT_USE_ANALOG = 1'b0, ROT_CW = 1'b0, TORQUE_CW = 1'b0;
    logic [1:0] BRAKE_MODE = 2'h0;
    logic [2:0] SPEED_DISPLAY_POINT_POS = 3'h0;
    logic [5:0] RMS_TORQUE_TIME_CONST = 6'h1E;
    logic [7:0] OUT_FUNC = 8'h00, OUTPUT_INVERT_MASK = 8'h00, COINCIDENCE_MIN_WIDTH = 8'h14, TORQUE_LIMIT_METHOD = 8'h11;
    logic [8:0] INPUT_INVERT_MASK = 9'h000;
    logic [9:0] BRAKE_THRESHOLD = 10'h1F4, SPEED_PCT = 10'h000, REGEN_OHMS = 10'h064, TORQUE_PCT = 10'h000;
    logic [9:0] SECOND_ANALOG_REFERENCE = 10'h12C, GENERAL_TORQUE_LIMIT = 10'h0C8, CCW_MOTORING_TORQUE_LIMIT = 10'h101;
    logic [9:0] CCW_BRAKING_TORQUE_LIMIT = 10'h102, CW_MOTORING_TORQUE_LIMIT = 10'h103, CW_BRAKING_TORQUE_LIMIT = 10'h104;
    logic [9:0] SPEED_LIMIT_ANALOG = 10'h0C8, SPEED_LIMIT_PARAM = 10'h190;
    logic [11:0] JOG_SPEED = 12'h032;
    logic [14:0] SPEED_DISPLAY_NUMERATOR = 15'h0001, SPEED_DISPLAY_DENOMINATOR = 15'h0001;
    logic [15:0] REGEN_KW = 16'h01F4, MOTOR_SPEED = 16'h0000;
    logic [8:0] DISCRETE_IN;
    logic CMD_STEP, CMD_UP, MOTOR_STEP, MOTOR_CW, BRAKE_ENGAGE, JOG_ACTIVE, REGEN_INTERNAL;
    logic TORQUE_LIMIT_ACTIVE, SPEED_LIMIT_ACTIVE, MARKER_STOP, POSITION_LOCK;
    logic [7:0] DISCRETE_OUT;
    logic [2:0] SPEED_POINT_POS;
    logic [9:0] REGEN_OHMS_ACT, RMS_TORQUE_READOUT, TORQUE_LIMIT_PCT, SPEED_LIMIT_PCT;
    logic [11:0] JOG_SPEED_CMD;
    logic [15:0] REGEN_KW_ACT, SPEED_DISPLAY;
    sdl_mode_t CONTROL_MODE;
    int n_mismatch = 0;
    int num_checks = 0;
    always #12.5 MCLK = ~MCLK;
    sdl_ctrl_model ctl (.MCLK, .DISCRETE_IN, .CMD_STEP, .CMD_UP);
    sdl_servo_logic dut (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge MCLK);
        #2;
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_regen();
        wt(2);
        chk({REGEN_OHMS_ACT, REGEN_INTERNAL}, {10'h064, 1'b0});
        REGEN_OHMS = 10'h000;
        REGEN_KW = 16'h0000;
        wt(3);
        chk({REGEN_OHMS_ACT, REGEN_KW_ACT}, {10'h064, 16'h01F4});
        NRST = 1'b0;
        wt(2);
        NRST = 1'b1;
        wt(2);
        chk({REGEN_OHMS_ACT, REGEN_INTERNAL}, {10'h000, 1'b1});
    endtask
    task automatic t_modes();
        for (int i = 0; i < 8; i++)
        begin
            INPUT_INVERT_MASK = i[2] ? 9'h018 : 9'h000;
            SPEED_LIMIT_USE_ANALOG = i[2];
            ctl.sel(i[1] ^ i[2], i[0] ^ i[2]);
            wt(4);
            chk(CONTROL_MODE, i[1] ? MODE_TORQUE : (i[0] ? MODE_POSITION : MODE_SPEED));
            chk(SPEED_LIMIT_ACTIVE, i[1]);
            if (i[1])
                chk(SPEED_LIMIT_PCT, i[2] ? 10'h0C8 : 10'h190);
        end
        INPUT_INVERT_MASK = 9'h000;
        ctl.sel(1'b0, 1'b0);
        wt(4);
    endtask
    task automatic t_steps();
        for (int i = 0; i < 4; i++)
        begin
            CMD_POLARITY = i[1];
            wt(2);
            ctl.step(i[0]);
            chk({MOTOR_STEP, MOTOR_CW}, {1'b1, i[0] == i[1]});
        end
    endtask
    task automatic t_brake();
        logic lo;
        for (int m = 0; m < 4; m++)
        begin
            BRAKE_MODE = m[1:0];
            SPEED_PCT = 10'h1F3;
            wt(4);
            lo = BRAKE_ENGAGE;
            SPEED_PCT = 10'h1F4;
            wt(4);
            if (m == 0)
                chk(BRAKE_ENGAGE, lo);
            else
                chk({lo, BRAKE_ENGAGE}, (m == 3) ? 2'h0 : 2'h2);
        end
    endtask
    task automatic t_tlim();
        logic [9:0] qexp[4] = '{10'h101, 10'h102, 10'h104, 10'h103};
        ctl.sel(1'b0, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            TORQUE_LIMIT_METHOD = {4'(i / 2), 4'h1};
            ctl.pin(IN_TORQUE_LIMIT_EN, i[0]);
            wt(4);
            chk(TORQUE_LIMIT_ACTIVE, i[0] || i >= 4);
            if (i[0] || i >= 4)
                chk(TORQUE_LIMIT_PCT, (i < 2) ? 10'h12C : 10'h0C8);
        end
        ctl.sel(1'b0, 1'b0);
        GENERAL_TORQUE_LIMIT = 10'h000;
        for (int q = 0; q < 4; q++)
        begin
            ROT_CW = q[1];
            TORQUE_CW = q[0];
            wt(4);
            chk(TORQUE_LIMIT_PCT, qexp[q]);
        end
        ctl.pin(IN_TORQUE_LIMIT_EN, 1'b0);
        TORQUE_LIMIT_METHOD = 8'h11;
    endtask
    task automatic t_jog();
        logic [23:0] jt[4] = '{24'h000001, 24'h001001, 24'hFA0FA0, 24'hFFFFA0};
        JOG_REQ = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            JOG_SPEED = jt[i][23:12];
            wt(4);
            chk({JOG_ACTIVE, JOG_SPEED_CMD}, {1'b1, jt[i][11:0]});
        end
        JOG_REQ = 1'b0;
        wt(4);
        chk({JOG_ACTIVE, JOG_SPEED_CMD}, 13'h0000);
    endtask
    task automatic t_disp();
        logic [61:0] dt[3] = '{{16'h03E8, 15'h3, 15'h2, 16'h05DC}, {16'h03E8, 15'h3, 15'h0, 16'h0BB8},
            {16'hFFFF, 15'h7FFF, 15'h1, 16'h8001}};
        SPEED_DISPLAY_POINT_POS = 3'h7;
        for (int i = 0; i < 3; i++)
        begin
            {MOTOR_SPEED, SPEED_DISPLAY_NUMERATOR, SPEED_DISPLAY_DENOMINATOR} = dt[i][61:16];
            wt(4);
            chk({SPEED_DISPLAY, SPEED_POINT_POS}, {dt[i][15:0], 3'h7});
        end
    endtask
    task automatic t_marker();
        ctl.pin(IN_STOP_MARKER, 1'b1);
        wt(5);
        chk({MARKER_STOP, POSITION_LOCK}, 2'h2);
        AT_MARKER = 1'b1;
        wt(2);
        chk({MARKER_STOP, POSITION_LOCK}, 2'h3);
        ctl.step(1'b1);
        chk(MOTOR_STEP, 1'b0);
        ctl.pin(IN_STOP_MARKER, 1'b0);
        AT_MARKER = 1'b0;
        wt(5);
        chk({MARKER_STOP, POSITION_LOCK}, 2'h0);
    endtask
    task automatic t_coin();
        OUT_FUNC = 8'h0A;
        OUTPUT_INVERT_MASK = 8'h4B;
        COINCIDENCE_MIN_WIDTH = 8'h00;
        TORQUE_PCT = 10'h3E8;
        RMS_TORQUE_TIME_CONST = 6'h01;
        wt(4);
        chk(DISCRETE_OUT, 8'h41);
        OUTPUT_INVERT_MASK = 8'h00;
        COINCIDENCE_RAW = 1'b1;
        wt(3);
        chk(DISCRETE_OUT, 8'h0B);
        COINCIDENCE_RAW = 1'b0;
        wt(3);
        chk(DISCRETE_OUT[0], 1'b0);
        COINCIDENCE_MIN_WIDTH = 8'h01;
        wt(2);
        COINCIDENCE_RAW = 1'b1;
        wt(1);
        COINCIDENCE_RAW = 1'b0;
        wt(39500);
        chk(DISCRETE_OUT[0], 1'b1);
        for (int k = 0; k < 41000 && DISCRETE_OUT[0] !== 1'b0; k++)
            wt(1);
        chk(DISCRETE_OUT[0], 1'b0);
        // Two 1 ms steps of a 1 s filter on full torque leave a mean square of 1999
        chk(RMS_TORQUE_READOUT, 10'h02C);
    endtask
    initial
    begin
        #2500000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        wt(17);
        chk({TORQUE_LIMIT_PCT, SPEED_LIMIT_PCT, CONTROL_MODE}, {10'h3E8, 10'h3E8, MODE_SPEED});
        chk({DISCRETE_OUT, BRAKE_ENGAGE, JOG_ACTIVE, POSITION_LOCK, MOTOR_STEP}, 12'h000);
        wt(3);
        NRST = 1'b1;
        t_regen();
        t_modes();
        t_steps();
        t_brake();
        t_tlim();
        t_jog();
        t_disp();
        t_marker();
        t_coin();
        complete_run();
    end
endmodule
